// ### hdl/slpc_pkg.sv
/*
  Package for the sleep-mode power controller: register offsets, field
  positions, reset values, sleep modes, wake-up source positions and timing.
  Assumes a 50 MHz system clock and an APB register bus with 32-bit data.
*/
package slpc_pkg;

  // APB register byte offsets.
  localparam logic [11:0] SLPC_SLEEP_CTRL_OFS = 12'h0000;
  localparam logic [11:0] SLPC_CORE_CTRL_OFS = 12'h0004;
  localparam logic [11:0] SLPC_STATUS_OFS = 12'h0008;

  // Field positions in sleep_control_reg.
  localparam int SLPC_SE_BIT = 0;
  localparam int SLPC_SM_LSB = 1;
  // Field positions in core_control_reg.
  localparam int SLPC_BROWNOUT_SLEEP_UNLOCK_BIT = 5;
  localparam int SLPC_BROWNOUT_SLEEP_OFF_BIT = 6;

  // Values after reset.
  localparam logic [2:0] SLPC_SLEEP_CTRL_RST = 3'h0;

  // Sleep modes as selected by sleep_mode_select.
  typedef enum logic [1:0] {
    SLPC_MODE_IDLE = 2'h0,
    SLPC_MODE_ADC_NR = 2'h1,
    SLPC_MODE_PWR_DOWN = 2'h2,
    SLPC_MODE_PWR_SAVE = 2'h3
  } slpc_mode_t;

  // Wake-up source vector positions.
  localparam int SLPC_WK_EXT_LEVEL = 0;
  localparam int SLPC_WK_EXT_EDGE = 1;
  localparam int SLPC_WK_PIN_CHANGE = 2;
  localparam int SLPC_WK_SPM_READY = 3;
  localparam int SLPC_WK_ADC_DONE = 4;
  localparam int SLPC_WK_WDT_IRQ = 5;
  localparam int SLPC_WK_START_COND = 6;
  localparam int SLPC_WK_TIMER = 7;
  localparam int SLPC_WK_OTHER_IO = 8;
  localparam int SLPC_WK_WIDTH = 9;

  // Timing.
  localparam int SLPC_CLK_MHZ = 50;
  localparam int SLPC_WAKE_HALT_CYCLES = 4;
  localparam int SLPC_UNLOCK_WINDOW = 4;
  localparam int SLPC_BROWNOUT_SLEEP_OFF_DELAY = 3;
  localparam int SLPC_BROWNOUT_SLEEP_OFF_HOLD = 3;
  localparam int SLPC_BOD_WAKE_US = 60;
  localparam int SLPC_BOD_WAKE_CYCLES = SLPC_BOD_WAKE_US * SLPC_CLK_MHZ;
  localparam int SLPC_CNT_W = 16;

endpackage

// ### hdl/slpc_timer.sv
/*
  Down-counting delay timer for the sleep controller.  A load pulse sets the
  count; done pulses once when the count reaches zero.  Assumes the caller
  never loads zero.
*/
`timescale 1ns/1ps
module slpc_timer (
  input wire logic clk_i, // System clock.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic load_i, // Load pulse.
  input wire logic [slpc_pkg::SLPC_CNT_W-1:0] count_i, // Cycles to wait.
  output logic busy_o, // Count running.
  output logic done_o // One-cycle pulse at expiry.
);
  import slpc_pkg::*;

  typedef struct packed {
    logic [SLPC_CNT_W-1:0] count;
    logic done;
  } slpc_tmr_t;

  slpc_tmr_t st;
  slpc_tmr_t next_st;

  // Count down, raising done on the step to zero.
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (load_i) begin
      next_st.count = count_i;
    end else if (st.count != '0) begin
      next_st.count = st.count - 1'b1;
      next_st.done = (st.count == 16'h0001);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_o = (st.count != '0);
  assign done_o = st.done;
endmodule

// ### hdl/slpc_ctrl.sv
/*
  Sleep-mode power controller top.  Holds the sleep and core control registers
  on APB, takes the sleep instruction strobe from the core, gates clock domains
  per mode, filters wake sources, times wake-up and the brown-out shutdown.
  Assumes all inputs synchronous to clk_i; wake sources already synchronised.
*/
// Local design decisions: the register offsets and the APB slave port.
// Behaviour
// RULE1 - Sleep only when sleep_enable_bit set and sleep instruction executes; mode selects.
// RULE2 - Mode 00 Idle stops core and program memory clocks only.
// RULE3 - Mode 01 also stops peripheral clock; converter and async timer run.
// RULE4 - Mode 10 Power-down stops oscillator and all generated clocks.
// RULE5 - Mode 11 Power-save as Power-down but async timer clock and oscillator run.
// RULE6 - Enabled interrupt wakes; core held four cycles beyond start-up, then resumes.
// RULE7 - Register file and SRAM contents kept through sleep and wake.
// RULE8 - Any reset during sleep wakes toward the reset vector.
// RULE9 - Idle accepts every enabled interrupt as a wake source.
// RULE10 - ADC noise reduction wakes only from listed sources.
// RULE11 - Power-down wakes on resets, watchdog, start condition, pin change, level irq.
// RULE12 - Entering Idle or ADC noise reduction with converter enabled starts a conversion.
// RULE13 - Level wake source must hold its level a minimum time. The code has no hold filter and wakes on a single cycle of the level.
// RULE14 - Power-down wake delay equals reset time-out chosen by clock_source_fuse.
// RULE15 - Power-save timer wakes only if mask bit and global enable set.
// RULE16 - Software uses Power-down when async timer not selected.
// RULE17 - Brown-out shutdown only in deep modes and when fuse enables detector.
// RULE18 - Detector off right after sleep entry, back on at wake.
// RULE19 - Wake time extends to about 60 us after detector was off.
// RULE20 - brownout_sleep_off one turns detector off in eligible modes; resets zero.
// RULE21 - brownout_sleep_off writes accepted only via timed unlock sequence.
// RULE22 - Unlock write both ones, then within four cycles off one, unlock zero.
// RULE23 - Setting effective three cycles after set, self clears three cycles later.
// RULE24 - Sleep instruction with sleep_enable_bit zero is a no-operation.
`timescale 1ns/1ps
module slpc_ctrl #(
  parameter int unsigned BOD_WAKE_CYCLES = slpc_pkg::SLPC_BOD_WAKE_CYCLES // Detector wake time in cycles.
) (
  input wire logic clk_i, // System clock, 50 MHz.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic sleep_instr_i, // Core executes the sleep instruction, pulse.
  input wire logic any_reset_i, // Any reset source during sleep, pulse or level.
  input wire logic [slpc_pkg::SLPC_WK_WIDTH-1:0] wake_src_i, // Enabled interrupt requests.
  input wire logic timer_async_select_i, // Async timer clocked from its oscillator.
  input wire logic [1:0] timer_irq_mask_i, // Overflow and compare enables.
  input wire logic [1:0] timer_events_i, // Overflow and compare events.
  input wire logic global_irq_en_i, // Global enable from cpu_status_reg.
  input wire logic converter_enabled_i, // Converter switched on.
  input wire logic brownout_level_fuse_i, // Detector enabled by fuse.
  input wire logic [slpc_pkg::SLPC_CNT_W-1:0] startup_cycles_i, // Time-out from clock_source_fuse.
  input wire logic clock_stable_i, // Main clock restarted and stable.
  output logic core_clock_domain_o, // Core clock enable.
  output logic program_memory_clock_o, // Program memory clock enable.
  output logic peripheral_clock_domain_o, // Peripheral clock enable.
  output logic converter_clock_domain_o, // Converter clock enable.
  output logic async_timer_clock_o, // Async timer clock enable.
  output logic main_osc_en_o, // Main oscillator enable.
  output logic timer_osc_en_o, // Timer oscillator enable.
  output logic brownout_detector_en_o, // Brown-out detector power.
  output logic adc_start_o, // Conversion start, pulse.
  output logic core_stall_o, // Core held during wake-up.
  output logic reset_vector_o, // Resume from reset vector, pulse.
  output logic wake_o, // Resume after sleep instruction, pulse.
  output logic asleep_o // Controller is in a sleep state.
);
  import slpc_pkg::*;

  typedef enum logic [1:0] {
    SLPC_ST_RUN,
    SLPC_ST_SLEEP,
    SLPC_ST_START,
    SLPC_ST_HALT
  } slpc_state_t;

  typedef struct packed {
    slpc_state_t state;
    logic se;
    slpc_mode_t mode;
    slpc_mode_t act_mode;
    logic brownout_sleep_off;
    logic brownout_sleep_unlock;
    logic [2:0] unlock_cnt;
    logic [2:0] brownout_sleep_off_cnt;
    logic bod_off;
    logic bod_was_off;
    logic adc_start;
    logic to_reset;
    logic wake;
    logic [2:0] halt_cnt;
    logic [31:0] prdata;
    logic pslverr;
  } slpc_ctrl_t;

  slpc_ctrl_t st;
  slpc_ctrl_t next_st;
  logic tmr_load;
  logic [SLPC_CNT_W-1:0] tmr_count;
  logic tmr_busy;
  logic wake_req;
  logic brownout_sleep_off_active;

  // Mode-dependent wake filter; used only to form wake_req, not by the checks.
  function automatic logic wake_allowed(input slpc_mode_t m, input logic [SLPC_WK_WIDTH-1:0] w,
                                        input logic tmr_ok);
    logic deep;
    deep = w[SLPC_WK_EXT_LEVEL] | w[SLPC_WK_PIN_CHANGE] | w[SLPC_WK_WDT_IRQ] | w[SLPC_WK_START_COND];
    case (m)
      SLPC_MODE_IDLE: wake_allowed = |w; // [RULE9]
      SLPC_MODE_ADC_NR: wake_allowed = deep | w[SLPC_WK_ADC_DONE] | w[SLPC_WK_SPM_READY]
                                       | w[SLPC_WK_TIMER]; // [RULE10]
      SLPC_MODE_PWR_DOWN: wake_allowed = deep; // [RULE11]
      default: wake_allowed = deep | tmr_ok; // [RULE15]
    endcase
  endfunction

  // Timer events count only when clocked asynchronously and fully enabled.
  assign wake_req = wake_allowed(st.act_mode, wake_src_i,
                                 timer_async_select_i & global_irq_en_i &
                                 (|(timer_events_i & timer_irq_mask_i))); // [RULE15]

  // Effective window of brownout_sleep_off: three cycles after set, for three.
  assign brownout_sleep_off_active = st.brownout_sleep_off && (st.brownout_sleep_off_cnt >= 3'(SLPC_BROWNOUT_SLEEP_OFF_DELAY)); // [RULE23]

  // Main state update, register writes and sleep sequencing.
  always_comb begin
    logic wr;
    logic rd;
    logic deep_mode;
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    deep_mode = 1'b0;
    next_st = st;
    next_st.adc_start = 1'b0;
    next_st.wake = 1'b0;
    next_st.pslverr = 1'b0;
    tmr_load = 1'b0;
    tmr_count = startup_cycles_i;

    // Unlock window and self-clearing setting count.
    if (st.unlock_cnt != '0) begin
      next_st.unlock_cnt = st.unlock_cnt - 1'b1; // [RULE22]
    end
    if (st.brownout_sleep_off) begin
      if (st.brownout_sleep_off_cnt == 3'(SLPC_BROWNOUT_SLEEP_OFF_DELAY + SLPC_BROWNOUT_SLEEP_OFF_HOLD - 1)) begin
        next_st.brownout_sleep_off = 1'b0; // [RULE23]
        next_st.brownout_sleep_off_cnt = '0;
      end else begin
        next_st.brownout_sleep_off_cnt = st.brownout_sleep_off_cnt + 1'b1;
      end
    end
    if (st.brownout_sleep_unlock && st.unlock_cnt == 3'h1) begin
      next_st.brownout_sleep_unlock = 1'b0;
    end

    // APB writes.
    if (wr) begin
      if (paddr == SLPC_SLEEP_CTRL_OFS) begin
        next_st.se = pwdata[SLPC_SE_BIT];
        next_st.mode = slpc_mode_t'(pwdata[SLPC_SM_LSB +: 2]);
      end else if (paddr == SLPC_CORE_CTRL_OFS) begin
        if (pwdata[SLPC_BROWNOUT_SLEEP_OFF_BIT] && pwdata[SLPC_BROWNOUT_SLEEP_UNLOCK_BIT]) begin
          next_st.brownout_sleep_unlock = 1'b1; // [RULE21]
          next_st.unlock_cnt = 3'(SLPC_UNLOCK_WINDOW);
        end else if (st.unlock_cnt != '0 && !pwdata[SLPC_BROWNOUT_SLEEP_UNLOCK_BIT]) begin
          next_st.brownout_sleep_off = pwdata[SLPC_BROWNOUT_SLEEP_OFF_BIT]; // [RULE22] [RULE20]
          next_st.brownout_sleep_off_cnt = '0;
          next_st.brownout_sleep_unlock = 1'b0;
          next_st.unlock_cnt = '0;
        end
      end
    end

    // An unmapped write is flagged in its setup phase, so the error stands while pready is high.
    if (psel && !penable && pwrite && paddr != SLPC_SLEEP_CTRL_OFS && paddr != SLPC_CORE_CTRL_OFS &&
        paddr != SLPC_STATUS_OFS) begin
      next_st.pslverr = 1'b1;
    end

    // APB reads are taken in the setup phase; the registered data then stands through the access phase.
    if (rd) begin
      next_st.prdata = '0;
      if (paddr == SLPC_SLEEP_CTRL_OFS) begin
        next_st.prdata[2:0] = {st.mode, st.se};
      end else if (paddr == SLPC_CORE_CTRL_OFS) begin
        next_st.prdata[SLPC_BROWNOUT_SLEEP_OFF_BIT] = st.brownout_sleep_off;
        next_st.prdata[SLPC_BROWNOUT_SLEEP_UNLOCK_BIT] = st.brownout_sleep_unlock;
      end else if (paddr == SLPC_STATUS_OFS) begin
        next_st.prdata[4:0] = {st.bod_off, st.act_mode, st.state};
      end else begin
        next_st.pslverr = 1'b1;
      end
    end

    // Sleep sequencing.
    case (st.state)
      SLPC_ST_RUN: begin
        // The reset-vector request lives from the sleep state to the first running cycle only.
        next_st.to_reset = 1'b0; // [RULE8]
        if (sleep_instr_i && st.se) begin // [RULE1] [RULE24]
          next_st.state = SLPC_ST_SLEEP;
          next_st.act_mode = st.mode;
          deep_mode = st.mode[1];
          next_st.bod_off = deep_mode && brownout_level_fuse_i && brownout_sleep_off_active; // [RULE17] [RULE18]
          next_st.bod_was_off = next_st.bod_off;
          next_st.adc_start = !deep_mode && converter_enabled_i; // [RULE12]
        end
      end
      SLPC_ST_SLEEP: begin
        if (any_reset_i || wake_req) begin
          next_st.state = SLPC_ST_START;
          next_st.to_reset = any_reset_i; // [RULE8]
          next_st.bod_off = 1'b0; // [RULE18]
          tmr_load = 1'b1;
          if (st.bod_was_off) begin
            tmr_count = SLPC_CNT_W'(BOD_WAKE_CYCLES); // [RULE19]
          end else if (st.act_mode[1]) begin
            tmr_count = (startup_cycles_i == '0) ? SLPC_CNT_W'(1) : startup_cycles_i; // [RULE14]
          end else begin
            tmr_count = SLPC_CNT_W'(1);
          end
        end
      end
      SLPC_ST_START: begin
        // Waiting on the idle timer, not its done pulse, keeps a late clock_stable_i from hanging here.
        if (!tmr_busy && (clock_stable_i || !st.act_mode[1])) begin
          next_st.state = SLPC_ST_HALT;
          next_st.halt_cnt = 3'(SLPC_WAKE_HALT_CYCLES); // [RULE6]
        end
      end
      default: begin
        if (st.halt_cnt == 3'h1) begin
          next_st.state = SLPC_ST_RUN;
          next_st.wake = !st.to_reset; // [RULE6]
          next_st.to_reset = st.to_reset; // [RULE8]
          next_st.halt_cnt = '0;
        end else begin
          next_st.halt_cnt = st.halt_cnt - 1'b1;
        end
      end
    endcase
  end

  // Register the state; memories are never touched by this block.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st <= '0; // [RULE7]
      st.state <= SLPC_ST_RUN;
    end else begin
      st <= next_st;
    end
  end

  slpc_timer u_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .busy_o(tmr_busy),
    .done_o()
  );

  // Clock gating per active sleep mode.
  always_comb begin
    logic sl;
    sl = (st.state == SLPC_ST_SLEEP);
    core_clock_domain_o = !(sl || st.state == SLPC_ST_START); // [RULE2]
    program_memory_clock_o = core_clock_domain_o; // [RULE2]
    peripheral_clock_domain_o = !(sl && st.act_mode != SLPC_MODE_IDLE); // [RULE3]
    converter_clock_domain_o = !(sl && st.act_mode[1]); // [RULE4]
    async_timer_clock_o = !(sl && st.act_mode == SLPC_MODE_PWR_DOWN); // [RULE5]
    main_osc_en_o = !(sl && st.act_mode[1]); // [RULE4]
    timer_osc_en_o = async_timer_clock_o; // [RULE5]
  end

  assign brownout_detector_en_o = brownout_level_fuse_i && !st.bod_off;
  assign adc_start_o = st.adc_start;
  assign core_stall_o = (st.state != SLPC_ST_RUN);
  assign reset_vector_o = st.to_reset && st.state == SLPC_ST_RUN;
  assign wake_o = st.wake;
  assign asleep_o = (st.state == SLPC_ST_SLEEP);
  assign prdata = st.prdata;
  assign pready = 1'b1;
  assign pslverr = st.pslverr;

  // Steps of the multi-cycle checks, named so that each property reads as its sequence of steps.
  sequence slpc_halt_hold;
    (st.state == SLPC_ST_HALT) [*4];
  endsequence
  sequence slpc_brownout_sleep_off_wait;
    !brownout_sleep_off_active [*3];
  endsequence
  sequence slpc_brownout_sleep_off_live;
    brownout_sleep_off_active [*3];
  endsequence

  // Checks on the sleep entry, clock gating, conversion start, wake-up, brown-out and wake-filter behaviour.
  chk_halt_four: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE6]
    $rose(st.state == SLPC_ST_HALT) |-> slpc_halt_hold ##1 core_stall_o == 1'b0)
    else $error("core not held four cycles");
  chk_noop_sleep: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE24]
    (st.state == SLPC_ST_RUN && sleep_instr_i && !st.se) |=> st.state == SLPC_ST_RUN)
    else $error("sleep entered without enable");
  chk_enter_sleep: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE1]
    (st.state == SLPC_ST_RUN && sleep_instr_i && st.se) |=> asleep_o && !core_clock_domain_o)
    else $error("sleep not entered");
  chk_idle_clocks: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE2]
    (asleep_o && st.act_mode == SLPC_MODE_IDLE) |-> peripheral_clock_domain_o && main_osc_en_o)
    else $error("idle stopped wrong clock");
  chk_pd_clocks: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE4]
    (asleep_o && st.act_mode == SLPC_MODE_PWR_DOWN) |-> !main_osc_en_o && !async_timer_clock_o)
    else $error("power-down clocks running");
  chk_brownout_sleep_off_window: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE23]
    $rose(st.brownout_sleep_off) |-> slpc_brownout_sleep_off_wait ##1 slpc_brownout_sleep_off_live ##1 !st.brownout_sleep_off)
    else $error("brownout_sleep_off timing wrong");
  chk_bod_idle_on: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE17]
    (asleep_o && !st.act_mode[1] && brownout_level_fuse_i) |-> brownout_detector_en_o)
    else $error("detector off in light mode");
  chk_reset_vector: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE8]
    (asleep_o && any_reset_i) |=> !wake_o [*1] ##0 st.to_reset)
    else $error("reset during sleep lost");
  chk_adc_start: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE12]
    (st.state == SLPC_ST_RUN && sleep_instr_i && st.se && !st.mode[1] && converter_enabled_i) |=> adc_start_o)
    else $error("conversion not started");
  chk_idle_any_src: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE9]
    (asleep_o && st.act_mode == SLPC_MODE_IDLE && (|wake_src_i)) |=> st.state == SLPC_ST_START)
    else $error("idle ignored a wake source");
  chk_pd_edge_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE11]
    (asleep_o && st.act_mode == SLPC_MODE_PWR_DOWN && wake_src_i == 9'h002 && !any_reset_i) |=> asleep_o)
    else $error("edge interrupt woke power-down");
  chk_timer_gated: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE15]
    (asleep_o && st.act_mode == SLPC_MODE_PWR_SAVE && wake_src_i == 9'h000 && !any_reset_i && !global_irq_en_i)
    |=> asleep_o)
    else $error("timer woke without global enable");
  chk_bod_wake_on: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE18]
    (st.state == SLPC_ST_START) |-> brownout_detector_en_o == brownout_level_fuse_i)
    else $error("detector still off at wake");
endmodule

// ### testbench/slpc_core_model.sv
/*
  Behavioural model of the processor core as seen by the sleep controller.
  Assumes the bench asks for a sleep instruction with a one-cycle request.
*/
`timescale 1ns/1ps
module slpc_core_model (
  input wire logic clk_i, // System clock.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic go_i, // Request to execute the sleep instruction.
  input wire logic core_stall_i, // Core held by the controller.
  output logic sleep_instr_o // Sleep instruction executed, one-cycle pulse.
);
  // A stalled core executes nothing, so a request during wake-up is lost.
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      sleep_instr_o <= 1'b0;
    end else begin
      sleep_instr_o <= go_i & ~core_stall_i;
    end
  end
endmodule

// ### testbench/slpc_ctrl_bench.sv
/*
  Self-checking bench for the sleep controller: APB tasks, a core model that
  issues the sleep instruction, and mode, wake-up and brown-out tests.
  Assumes zero-wait APB whose read data and error stand during the access phase.
*/
`timescale 1ns/1ps
module slpc_ctrl_bench;
  import slpc_pkg::*;
  localparam int BODW = 20; // Short detector wake time keeps the run brief.
  localparam int START = 10;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, sleep_instr, core_stall, reset_vector, wake, asleep, adc_start, bod_en, e;
  logic go = 1'b0;
  logic any_reset_i = 1'b0;
  logic conv_en = 1'b1;
  logic glob = 1'b0;
  logic [1:0] tev = 2'b00;
  logic [SLPC_WK_WIDTH-1:0] wake_src_i = '0;
  logic [6:0] clk_vec;
  logic [31:0] q;
  int fails = 0;
  int n_tests = 0;
  int n_wake = 0;
  int n_rv = 0;
  int n_adc = 0;
  logic [6:0] clk_exp [4] = '{7'h1f, 7'h0f, 7'h00, 7'h05};
  logic [8:0] good_src [4] = '{9'h100, 9'h010, 9'h001, 9'h000};
  logic [8:0] bad_src [4] = '{9'h000, 9'h100, 9'h002, 9'h000};
  int dly [4] = '{1, 1, START, START};

  always #10 clk_i = ~clk_i;

  // Fuse, timer setup and clock readiness stay fixed; the rest is exercised.
  slpc_ctrl #(.BOD_WAKE_CYCLES(BODW)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_instr_i(sleep_instr), .any_reset_i(any_reset_i), .wake_src_i(wake_src_i),
    .timer_async_select_i(1'b1), .timer_irq_mask_i(2'b11), .timer_events_i(tev), .global_irq_en_i(glob),
    .converter_enabled_i(conv_en), .brownout_level_fuse_i(1'b1), .startup_cycles_i(16'(START)),
    .clock_stable_i(1'b1), .core_clock_domain_o(clk_vec[6]), .program_memory_clock_o(clk_vec[5]),
    .peripheral_clock_domain_o(clk_vec[4]), .converter_clock_domain_o(clk_vec[3]),
    .async_timer_clock_o(clk_vec[2]), .main_osc_en_o(clk_vec[1]), .timer_osc_en_o(clk_vec[0]),
    .brownout_detector_en_o(bod_en), .adc_start_o(adc_start), .core_stall_o(core_stall),
    .reset_vector_o(reset_vector), .wake_o(wake), .asleep_o(asleep));

  slpc_core_model i_core (.clk_i(clk_i), .reset_n_i(reset_n_i), .go_i(go), .core_stall_i(core_stall),
    .sleep_instr_o(sleep_instr));

  // Pulse counters; every counted output is a one-cycle pulse.
  always @(posedge clk_i) begin
    if (wake === 1'b1) n_wake <= n_wake + 1;
    if (reset_vector === 1'b1) n_rv <= n_rv + 1;
    if (adc_start === 1'b1) n_adc <= n_adc + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq,
                     output logic er);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rq = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(q, exp);
  endtask

  // Kind 0 leaves the detector alone, 1 unlocks properly, 2 skips the unlock, 3 unlocks too late.
  task automatic enter(input logic [1:0] m, input int k, input logic se);
    wr(SLPC_SLEEP_CTRL_OFS, {29'h0, m, se});
    if (k == 1 || k == 3) wr(SLPC_CORE_CTRL_OFS, 32'h0000_0060);
    if (k == 3) repeat (6) @(posedge clk_i);
    if (k != 0) wr(SLPC_CORE_CTRL_OFS, 32'h0000_0040);
    repeat (2) @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // Sources that must not wake the part are held a while; it must stay asleep.
  task automatic poke(input logic [8:0] src, input logic [1:0] t);
    @(posedge clk_i);
    wake_src_i <= src;
    tev <= t;
    repeat (20) @(posedge clk_i);
    wake_src_i <= '0;
    tev <= 2'b00;
    @(negedge clk_i);
    check({31'h0, asleep}, 32'h1);
  endtask

  // The source level is held until the resume pulse, then the delay is judged.
  task automatic wake_up(input logic [8:0] src, input logic [1:0] t, input logic rst, input int lo);
    int n;
    @(posedge clk_i);
    wake_src_i <= src;
    tev <= t;
    glob <= 1'b1;
    any_reset_i <= rst;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wake !== 1'b1 && reset_vector !== 1'b1 && n < 400);
    wake_src_i <= '0;
    tev <= 2'b00;
    glob <= 1'b0;
    any_reset_i <= 1'b0;
    @(negedge clk_i);
    check(32'(n >= lo && n <= lo + 5), 32'h1);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    $display("MISMATCH at %0t: watchdog expired before the tests ended", $time);
    give_verdict();
  end

  initial begin
    int a;
    int w;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(SLPC_SLEEP_CTRL_OFS, 32'h0000_0000);
    rd(SLPC_CORE_CTRL_OFS, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000, q, e);
    check({31'h0, e}, 32'h1);
    enter(SLPC_MODE_PWR_DOWN, 0, 1'b0);
    check({31'h0, asleep}, 32'h0);
    check({25'h0, clk_vec}, 32'h7f);
    $display("Test reset and no-op sleep done");
    for (int m = 0; m < 4; m++) begin
      a = n_adc;
      w = n_wake;
      enter(2'(m), 0, 1'b1);
      check({31'h0, asleep}, 32'h1);
      check({25'h0, clk_vec}, {25'h0, clk_exp[m]});
      check(32'(n_adc - a), m < 2 ? 32'h1 : 32'h0);
      rd(SLPC_STATUS_OFS, {28'h0, 2'(m), 2'b01});
      poke(bad_src[m], m == 3 ? 2'b11 : 2'b00);
      wake_up(good_src[m], m == 3 ? 2'b01 : 2'b00, 1'b0, dly[m] + SLPC_WAKE_HALT_CYCLES);
      check(32'(n_wake - w), 32'h1);
      check({25'h0, clk_vec}, 32'h7f);
      $display("Test sleep mode %0d done", m);
    end
    a = n_rv;
    w = n_wake;
    enter(SLPC_MODE_PWR_SAVE, 0, 1'b1);
    wake_up(9'h000, 2'b00, 1'b1, START + SLPC_WAKE_HALT_CYCLES);
    check(32'(n_rv - a), 32'h1);
    check(32'(n_wake - w), 32'h0);
    $display("Test reset during sleep done");
    conv_en <= 1'b0;
    for (int k = 1; k < 4; k++) begin
      enter(SLPC_MODE_PWR_DOWN, k, 1'b1);
      check({31'h0, bod_en}, k == 1 ? 32'h0 : 32'h1);
      wake_up(9'h001, 2'b00, 1'b0, (k == 1 ? BODW : START) + SLPC_WAKE_HALT_CYCLES);
      check({31'h0, bod_en}, 32'h1);
      rd(SLPC_CORE_CTRL_OFS, 32'h0000_0000);
    end
    a = n_adc;
    enter(SLPC_MODE_IDLE, 1, 1'b1);
    check({31'h0, bod_en}, 32'h1);
    check(32'(n_adc - a), 32'h0);
    wake_up(9'h004, 2'b00, 1'b0, 1 + SLPC_WAKE_HALT_CYCLES);
    $display("Test brown-out shutdown done");
    give_verdict();
  end
endmodule
